/* File: rtl/dcf_fifo.sv */
// Dual-clock FIFO control core with pin samplers and register port
`timescale 1ns/1ps

module dcf_fifo (
   // Clock, reset, freeze
   input  wire logic                         sys_clk_i,
   input  wire logic                         reset_n_i,
   input  wire logic                         clk_en_i,
   // Device resets
   input  wire logic                         master_reset_n_i,
   input  wire logic                         partial_reset_n_i,
   // Write port
   input  wire logic                         write_clk_i,
   input  wire logic                         write_enable_n_i,
   input  wire logic [dcf_pkg::DATA_W-1:0]   write_data_i,
   input  wire logic                         offset_load_n_i,
   input  wire logic                         serial_enable_n_i,
   input  wire logic                         mode_select_serial_in_i,
   // Read port
   input  wire logic                         read_clk_i,
   input  wire logic                         read_enable_n_i,
   input  wire logic                         retransmit_n_i,
   output logic [dcf_pkg::DATA_W-1:0]        read_data_o,
   // Status flags
   output logic                              empty_flag_n_o,
   output logic                              full_flag_n_o,
   output logic                              almost_empty_n_o,
   output logic                              almost_full_n_o,
   output logic                              half_full_n_o,
   // Register port
   input  wire logic [1:0]                   reg_addr_i,
   input  wire logic [dcf_pkg::OFS_W-1:0]    reg_wdata_i,
   input  wire logic                         reg_write_i,
   input  wire logic                         reg_read_i,
   output logic [dcf_pkg::OFS_W-1:0]         reg_rdata_o
);

   // Sampled pin bundles and settings
   dcf_pins_if #(.W(dcf_pkg::WR_PINS)) wpins ();
   dcf_pins_if #(.W(dcf_pkg::RD_PINS)) rpins ();
   dcf_cfg_if                          cfg ();

   // Core state
   logic [dcf_pkg::DATA_W-1:0]  mem [0:dcf_pkg::DEPTH-1];
   logic [dcf_pkg::PTR_W-1:0]   wptr;
   logic [dcf_pkg::PTR_W-1:0]   rptr;
   logic [dcf_pkg::PTR_W-1:0]   rptr_w1;
   logic [dcf_pkg::PTR_W-1:0]   wptr_r1;
   logic                        full;
   logic                        empty;
   logic                        out_valid;
   logic                        almost_empty_n;
   logic                        almost_full_n;
   logic                        half_full_n;
   logic [dcf_pkg::DATA_W-1:0]  dout;
   dcf_pkg::dcf_rt_state_t      rt_state;
   logic [1:0]                  rt_cnt;
   logic [dcf_pkg::OFS_W-1:0]   rdata;

   // Decode wires
   logic                        core_rst_n;
   logic                        wr_tick;
   logic                        wr_en_n;
   logic                        wr_load_n;
   logic                        wr_sen_n;
   logic [dcf_pkg::DATA_W-1:0]  wr_data;
   logic                        wr_do;
   logic                        shift_en;
   logic [dcf_pkg::PTR_W-1:0]   next_wptr;
   logic [dcf_pkg::PTR_W-1:0]   wlevel;
   logic                        next_full;
   logic                        af_hit;
   logic                        rd_tick;
   logic                        rd_en_n;
   logic                        rt_n;
   logic                        rt_idle;
   logic                        rt_take;
   logic                        rd_free;
   logic                        rd_take;
   logic                        ov_drop;
   logic                        next_ov;
   logic [dcf_pkg::PTR_W-1:0]   next_rptr;
   logic [dcf_pkg::PTR_W-1:0]   rlevel;
   logic                        next_empty;
   logic                        ae_hit;
   logic [dcf_pkg::PTR_W-1:0]   hlevel;
   logic [dcf_pkg::PTR_W-1:0]   hthr;
   logic                        hf_above;
   logic [dcf_pkg::OFS_W-1:0]   rd_mux;

   // Either device reset clears the data path at once
   assign core_rst_n = reset_n_i & master_reset_n_i & partial_reset_n_i;

   // Write side pins, clock in bit 0
   dcf_pin_sync #(.W(dcf_pkg::WR_PINS)) u_wsync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .pins_i    ({write_data_i, master_reset_n_i, mode_select_serial_in_i,
                   serial_enable_n_i, offset_load_n_i, write_enable_n_i, write_clk_i}),
      .sync_o    (wpins)
   );

   // Read side pins, clock in bit 0
   dcf_pin_sync #(.W(dcf_pkg::RD_PINS)) u_rsync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .pins_i    ({retransmit_n_i, read_enable_n_i, read_clk_i}),
      .sync_o    (rpins)
   );

   // Mode, method and offsets
   dcf_cfg_regs u_cfg (
      .sys_clk_i   (sys_clk_i),
      .reset_n_i   (reset_n_i),
      .clk_en_i    (clk_en_i),
      .mrs_level_i (wpins.level[dcf_pkg::WP_MRS]),
      .mode_i      (wpins.level[dcf_pkg::WP_SI]),
      .load_i      (wr_load_n),
      .shift_en_i  (shift_en),
      .shift_bit_i (wpins.level[dcf_pkg::WP_SI]),
      .bus_wr_i    (reg_write_i),
      .bus_addr_i  (reg_addr_i),
      .bus_wdata_i (reg_wdata_i),
      .cfg_o       (cfg)
   );

   // Write side decode
   assign wr_tick   = wpins.clk_rise;
   assign wr_en_n   = wpins.level[dcf_pkg::WP_EN];
   assign wr_load_n = wpins.level[dcf_pkg::WP_LOAD];
   assign wr_sen_n  = wpins.level[dcf_pkg::WP_SEN];
   assign wr_data   = wpins.level[dcf_pkg::WP_DATA +: dcf_pkg::DATA_W];
   assign wr_do     = wr_tick & ~wr_en_n & wr_load_n & ~full;
   assign shift_en  = wr_tick & ~wr_load_n & ~wr_sen_n;
   assign next_wptr = dcf_pkg::dcf_inc(wptr, wr_do);
   assign wlevel    = dcf_pkg::dcf_level(next_wptr, rptr_w1);
   assign next_full = (wlevel == dcf_pkg::DEPTH);
   assign af_hit    = (wlevel >= (dcf_pkg::DEPTH - cfg.full_ofs));

   // Read side decode
   assign rd_tick = rpins.clk_rise;
   assign rd_en_n = rpins.level[dcf_pkg::RP_EN];
   assign rt_n    = rpins.level[dcf_pkg::RP_RT];
   assign rt_idle = (rt_state == dcf_pkg::DCF_RT_IDLE);
   assign rt_take = rd_tick & ~rt_n & rt_idle;
   assign rd_free = rd_tick & rt_n & rt_idle;
   // Standard reads need enable; fall-through also refills an empty output
   assign rd_take = rd_free & ~empty &
                    (cfg.fall_through_mode ? (~out_valid | ~rd_en_n) : ~rd_en_n);
   assign ov_drop = rd_free & cfg.fall_through_mode & out_valid & ~rd_en_n & ~rd_take;
   assign next_ov = rt_take ? 1'b0 :
                    (rd_take & cfg.fall_through_mode) ? 1'b1 :
                    ov_drop ? 1'b0 : out_valid;
   assign next_rptr = rt_take ? dcf_pkg::PTR_RST : dcf_pkg::dcf_inc(rptr, rd_take);
   assign rlevel    = dcf_pkg::dcf_level(wptr_r1, next_rptr);
   // Held empty through retransmit setup
   assign next_empty = rt_take | ~rt_idle | (rlevel == dcf_pkg::PTR_RST);
   assign ae_hit     = (rlevel <= cfg.empty_ofs);

   // Half-full counts the output register in fall-through
   assign hlevel   = dcf_pkg::dcf_level(next_wptr, next_rptr) +
                     {{(dcf_pkg::PTR_W-1){1'b0}}, cfg.fall_through_mode & next_ov};
   assign hthr     = dcf_pkg::HALF_DEPTH + {{(dcf_pkg::PTR_W-1){1'b0}}, cfg.fall_through_mode};
   assign hf_above = (hlevel > hthr);

   // Array write, no reset on storage
   always_ff @(posedge sys_clk_i) begin
      if (clk_en_i && wr_do) begin
         mem[wptr[dcf_pkg::ADDR_W-1:0]] <= wr_data;
      end
   end

   // Write domain: pointer, read pointer copy, full and almost-full
   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         wptr          <= dcf_pkg::PTR_RST;
         rptr_w1       <= dcf_pkg::PTR_RST;
         full          <= 1'b0;
         almost_full_n <= 1'b1;
      end else if (clk_en_i && wr_tick) begin
         wptr          <= next_wptr;
         rptr_w1       <= rptr;
         full          <= next_full;
         almost_full_n <= ~af_hit;
      end
   end

   // Read domain: pointer, write pointer copy, empty, output register
   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         rptr           <= dcf_pkg::PTR_RST;
         wptr_r1        <= dcf_pkg::PTR_RST;
         empty          <= 1'b1;
         out_valid      <= 1'b0;
         dout           <= dcf_pkg::DOUT_RST;
         almost_empty_n <= 1'b0;
      end else if (clk_en_i && rd_tick) begin
         rptr           <= next_rptr;
         wptr_r1        <= wptr;
         empty          <= next_empty;
         out_valid      <= next_ov;
         almost_empty_n <= ~ae_hit;
         if (rd_take) begin
            dout <= mem[rptr[dcf_pkg::ADDR_W-1:0]];
         end
      end
   end

   // Retransmit setup sequencer
   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         rt_state <= dcf_pkg::DCF_RT_IDLE;
         rt_cnt   <= 2'h0;
      end else if (clk_en_i && rd_tick) begin
         unique case (rt_state)
            dcf_pkg::DCF_RT_IDLE: begin
               if (!rt_n) begin
                  rt_state <= dcf_pkg::DCF_RT_SETUP;
                  rt_cnt   <= dcf_pkg::RT_SETUP_EDGES;
               end
            end
            dcf_pkg::DCF_RT_SETUP: begin
               rt_cnt <= rt_cnt - 2'h1;
               if (rt_cnt == 2'h1) begin
                  rt_state <= dcf_pkg::DCF_RT_IDLE;
               end
            end
            default: begin
               rt_state <= dcf_pkg::DCF_RT_IDLE;
               rt_cnt   <= 2'h0;
            end
         endcase
      end
   end

   // Half-full: write edges only lower it, read edges only raise it
   always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         half_full_n <= 1'b1;
      end else if (clk_en_i) begin
         if (wr_tick && hf_above) begin
            half_full_n <= 1'b0;
         end else if (rd_tick && !hf_above) begin
            half_full_n <= 1'b1;
         end
      end
   end

   // Register read selection
   assign rd_mux = (reg_addr_i == dcf_pkg::REG_EMPTY_OFS) ? cfg.empty_ofs :
                   (reg_addr_i == dcf_pkg::REG_FULL_OFS)  ? cfg.full_ofs :
                   (reg_addr_i == dcf_pkg::REG_LEVEL)     ? dcf_pkg::dcf_level(wptr, rptr) :
                   {8'h00, cfg.fall_through_mode, cfg.serial_load, half_full_n, out_valid,
                    almost_full_n, almost_empty_n, full, empty};

   // Read data stands for one cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata <= 16'h0000;
      end else if (clk_en_i) begin
         rdata <= reg_read_i ? rd_mux : 16'h0000;
      end
   end

   // Pin mapping of the dual-purpose flags
   assign empty_flag_n_o   = cfg.fall_through_mode ? ~out_valid : ~empty;
   assign full_flag_n_o    = cfg.fall_through_mode ? full : ~full;
   assign almost_empty_n_o = almost_empty_n;
   assign almost_full_n_o  = almost_full_n;
   assign half_full_n_o    = half_full_n;
   assign read_data_o      = dout;
   assign reg_rdata_o      = rdata;

endmodule : dcf_fifo

/* File: rtl/dcf_pkg.sv */
// Shared constants, types and helpers of the dual-clock FIFO controller
package dcf_pkg;
   // Data path and pointer widths
   localparam int unsigned DATA_W  = 18;
   localparam int unsigned ADDR_W  = 15;
   localparam int unsigned PTR_W   = 16;
   localparam int unsigned OFS_W   = 16;
   // Depth of the array and the half-full point
   localparam logic [PTR_W-1:0] DEPTH      = 16'h8000;
   localparam logic [PTR_W-1:0] HALF_DEPTH = 16'h4000;
   // Offset defaults picked at master reset
   localparam logic [OFS_W-1:0] OFS_PARALLEL_RST = 16'h007F;
   localparam logic [OFS_W-1:0] OFS_SERIAL_RST   = 16'h03FF;
   // Reset values of the core
   localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
   localparam logic [DATA_W-1:0] DOUT_RST = 18'h00000;
   // Read edges spent in retransmit setup
   localparam logic [1:0] RT_SETUP_EDGES = 2'h2;
   // Bit positions of the sampled write and read pin bundles
   localparam int unsigned WR_PINS = 24;
   localparam int unsigned RD_PINS = 3;
   localparam int unsigned WP_CLK  = 0;
   localparam int unsigned WP_EN   = 1;
   localparam int unsigned WP_LOAD = 2;
   localparam int unsigned WP_SEN  = 3;
   localparam int unsigned WP_SI   = 4;
   localparam int unsigned WP_MRS  = 5;
   localparam int unsigned WP_DATA = 6;
   localparam int unsigned RP_CLK  = 0;
   localparam int unsigned RP_EN   = 1;
   localparam int unsigned RP_RT   = 2;
   // Register port offsets
   localparam logic [1:0] REG_EMPTY_OFS = 2'h0;
   localparam logic [1:0] REG_FULL_OFS  = 2'h1;
   localparam logic [1:0] REG_LEVEL     = 2'h2;
   localparam logic [1:0] REG_STATUS    = 2'h3;
   // Retransmit sequencer states
   typedef enum logic [1:0] {
      DCF_RT_IDLE  = 2'b01,
      DCF_RT_SETUP = 2'b10
   } dcf_rt_state_t;
   // Pointer advance by one when enabled
   function automatic logic [PTR_W-1:0] dcf_inc(input logic [PTR_W-1:0] ptr, input logic en);
      return ptr + {{(PTR_W-1){1'b0}}, en};
   endfunction : dcf_inc
   // Words held between a write and a read pointer
   function automatic logic [PTR_W-1:0] dcf_level(input logic [PTR_W-1:0] wp,
                                                  input logic [PTR_W-1:0] rp);
      return wp - rp;
   endfunction : dcf_level
endpackage : dcf_pkg

/* File: rtl/dcf_ifs.sv */
// Interfaces between the FIFO control core and its helper modules
`timescale 1ns/1ps
interface dcf_pins_if #(parameter int unsigned W = 3);
   logic [W-1:0] level;    // Filtered levels, one system clock cycle behind
   logic         clk_rise; // One-cycle pulse per rising link clock
   modport drive (output level, output clk_rise);
   modport sink  (input level, input clk_rise);
endinterface : dcf_pins_if

interface dcf_cfg_if;
   logic                       fall_through_mode;        // Fall-through timing selected
   logic                       serial_load; // Serial offset loading selected
   logic [dcf_pkg::OFS_W-1:0]  empty_ofs;
   logic [dcf_pkg::OFS_W-1:0]  full_ofs;
   modport owner (output fall_through_mode, output serial_load, output empty_ofs, output full_ofs);
   modport sink  (input fall_through_mode, input serial_load, input empty_ofs, input full_ofs);
endinterface : dcf_cfg_if

/* File: rtl/dcf_pin_sync.sv */
// Three-stage pin sampler with agreement filter and clock edge finder
`timescale 1ns/1ps
module dcf_pin_sync #(
   parameter int unsigned W = 3
) (
   // Clock, reset, freeze
   input  wire logic          sys_clk_i,
   input  wire logic          reset_n_i,
   input  wire logic          clk_en_i,
   // Raw pins, bit 0 is the link clock
   input  wire logic [W-1:0]  pins_i,
   // Filtered levels and edge pulse
   dcf_pins_if.drive          sync_o
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;
   logic [W-1:0] stable;
   logic [W-1:0] held;
   logic         rise;
   logic [W-1:0] next_stable;

   // A bit changes only once stages two and three agree
   assign next_stable = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & stable);

   // Sampling chain, idle high so no false edge after reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stage1 <= '1;
         stage2 <= '1;
         stage3 <= '1;
         stable <= '1;
         held   <= '1;
         rise   <= 1'b0;
      end else if (clk_en_i) begin
         stage1 <= pins_i;
         stage2 <= stage1;
         stage3 <= stage2;
         stable <= next_stable;
         held   <= stable;
         rise   <= next_stable[0] & ~stable[0];
      end
   end

   // Levels lag one cycle so data beside the edge is the pre-edge value
   assign sync_o.level    = held;
   assign sync_o.clk_rise = rise;
endmodule : dcf_pin_sync

/* File: rtl/dcf_cfg_regs.sv */
// Timing mode, loading method and flag offset registers
`timescale 1ns/1ps
module dcf_cfg_regs (
   // Clock, reset, freeze
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_n_i,
   input  wire logic                       clk_en_i,
   // Sampled pins
   input  wire logic                       mrs_level_i,
   input  wire logic                       mode_i,
   input  wire logic                       load_i,
   input  wire logic                       shift_en_i,
   input  wire logic                       shift_bit_i,
   // Register port writes
   input  wire logic                       bus_wr_i,
   input  wire logic [1:0]                 bus_addr_i,
   input  wire logic [dcf_pkg::OFS_W-1:0]  bus_wdata_i,
   // Settings to the core
   dcf_cfg_if.owner                        cfg_o
);
   logic                       fall_through_mode;
   logic                       serial_load;
   logic [dcf_pkg::OFS_W-1:0]  empty_ofs;
   logic [dcf_pkg::OFS_W-1:0]  full_ofs;
   logic [dcf_pkg::OFS_W-1:0]  default_ofs;
   logic                       par_wr_empty;
   logic                       par_wr_full;

   // Default offset and parallel write decode
   assign default_ofs  = load_i ? dcf_pkg::OFS_SERIAL_RST : dcf_pkg::OFS_PARALLEL_RST;
   assign par_wr_empty = bus_wr_i & ~serial_load & (bus_addr_i == dcf_pkg::REG_EMPTY_OFS);
   assign par_wr_full  = bus_wr_i & ~serial_load & (bus_addr_i == dcf_pkg::REG_FULL_OFS);

   // Capture during master reset, then load by the chosen method only
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fall_through_mode        <= 1'b0;
         serial_load <= 1'b0;
         empty_ofs   <= dcf_pkg::OFS_PARALLEL_RST;
         full_ofs    <= dcf_pkg::OFS_PARALLEL_RST;
      end else if (clk_en_i) begin
         if (!mrs_level_i) begin
            fall_through_mode        <= mode_i;
            serial_load <= load_i;
            empty_ofs   <= default_ofs;
            full_ofs    <= default_ofs;
         end else if (serial_load && shift_en_i) begin
            {full_ofs, empty_ofs} <= {full_ofs[dcf_pkg::OFS_W-2:0], empty_ofs, shift_bit_i};
         end else if (par_wr_empty) begin
            empty_ofs <= bus_wdata_i;
         end else if (par_wr_full) begin
            full_ofs <= bus_wdata_i;
         end
      end
   end

   assign cfg_o.fall_through_mode        = fall_through_mode;
   assign cfg_o.serial_load = serial_load;
   assign cfg_o.empty_ofs   = empty_ofs;
   assign cfg_o.full_ofs    = full_ofs;
endmodule : dcf_cfg_regs

/* File: verification/dcf_fifo_properties.sv */
// Port-level checks of the FIFO control core
`timescale 1ns/1ps
module dcf_fifo_properties (
   // Clock and resets
   input wire logic        sys_clk_i,
   input wire logic        reset_n_i,
   input wire logic        master_reset_n_i,
   input wire logic        partial_reset_n_i,
   // Link clocks and mode pin
   input wire logic        write_clk_i,
   input wire logic        read_clk_i,
   input wire logic        mode_select_serial_in_i,
   // Outputs watched
   input wire logic [17:0] read_data_o,
   input wire logic        empty_flag_n_o,
   input wire logic        full_flag_n_o,
   input wire logic        almost_empty_n_o,
   input wire logic        almost_full_n_o,
   input wire logic        half_full_n_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Both device resets released
   wire quiet = master_reset_n_i && partial_reset_n_i;
   property p_mrs; !master_reset_n_i |-> !almost_empty_n_o && almost_full_n_o
      && half_full_n_o && read_data_o == 18'h00000; endproperty
   a_mrs: assert property (p_mrs) else $error("master reset state wrong");
   property p_mode; (!master_reset_n_i && $stable(mode_select_serial_in_i))[*8] |->
      empty_flag_n_o == mode_select_serial_in_i && full_flag_n_o != mode_select_serial_in_i;
   endproperty
   a_mode: assert property (p_mode) else $error("mode flags wrong");
   property p_prs; !partial_reset_n_i |-> !almost_empty_n_o && almost_full_n_o
      && half_full_n_o && read_data_o == 18'h00000; endproperty
   a_prs: assert property (p_prs) else $error("partial reset state wrong");
   property p_prs_mode; !partial_reset_n_i |-> empty_flag_n_o != full_flag_n_o; endproperty
   a_prs_mode: assert property (p_prs_mode) else $error("partial flags wrong");
   property p_wr_frz; (quiet && $stable(write_clk_i))[*8] |-> $stable(full_flag_n_o); endproperty
   a_wr_frz: assert property (p_wr_frz) else $error("full moved idle");
   property p_hf_dn; (quiet && $stable(write_clk_i))[*8] |-> !$fell(half_full_n_o); endproperty
   a_hf_dn: assert property (p_hf_dn) else $error("half-full fell idle");
   property p_rd_frz; (quiet && $stable(read_clk_i))[*8] |-> $stable(empty_flag_n_o); endproperty
   a_rd_frz: assert property (p_rd_frz) else $error("empty moved idle");
   property p_hf_up; (quiet && $stable(read_clk_i))[*8] |-> !$rose(half_full_n_o); endproperty
   a_hf_up: assert property (p_hf_up) else $error("half-full rose idle");
endmodule : dcf_fifo_properties
bind dcf_fifo dcf_fifo_properties chk_u (.sys_clk_i, .reset_n_i, .master_reset_n_i,
   .partial_reset_n_i, .write_clk_i, .read_clk_i, .mode_select_serial_in_i, .read_data_o,
   .empty_flag_n_o, .full_flag_n_o, .almost_empty_n_o, .almost_full_n_o, .half_full_n_o);

/* File: verification/dcf_link_model.sv */
// Writer and reader, one link clock pulse per word, clocks still between words
`timescale 1ns/1ps
module dcf_link_model (
   // Write side pins
   output logic        write_clk_o,
   output logic        write_enable_n_o,
   output logic [17:0] write_data_o,
   // Read side pins
   output logic        read_clk_o,
   output logic        read_enable_n_o,
   output logic        retransmit_n_o
);
   initial begin
      {write_clk_o, read_clk_o} = 2'h0;
      {write_enable_n_o, read_enable_n_o, retransmit_n_o} = 3'h7;
      write_data_o = 18'h15555;
   end
   // One write pulse, data inverted once hold runs out
   task automatic wr(input logic en_n, input logic [17:0] d);
      #3 write_enable_n_o = en_n;
      write_data_o = d;
      #40 write_clk_o = 1'b1;
      #80 write_clk_o = 1'b0;
      #40 write_enable_n_o = 1'b1;
      write_data_o = ~d;
   endtask : wr
   // One read pulse; retransmit only with read enable high
   task automatic rd(input logic en_n, input logic rt_n);
      #3 read_enable_n_o = en_n | ~rt_n;
      retransmit_n_o = rt_n;
      #40 read_clk_o = 1'b1;
      #80 read_clk_o = 1'b0;
      #40 read_enable_n_o = 1'b1;
      retransmit_n_o = 1'b1;
   endtask : rd
endmodule : dcf_link_model

/* File: verification/test_dual_clock_fifo_control.sv */
// Self-checking bench of the FIFO control core
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_dual_clock_fifo_control;
   logic        sys_clk = 1'b0, reset_n = 1'b0, mrs_n = 1'b1, prs_n = 1'b1;
   logic        load_n = 1'b1, sen_n = 1'b1, si = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0]  reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, v, ofs;
   logic [31:0] sv;
   logic [17:0] rdata, wdata, q [4];
   logic        wclk, wen_n, rclk, ren_n, rt_n, ef_n, ff_n, ae_n, af_n, hf_n;
   int          seed = 45, errors = 0, comparisons = 0;
   always #4 sys_clk = ~sys_clk;
   dcf_link_model lnk_u (.write_clk_o(wclk), .write_enable_n_o(wen_n), .write_data_o(wdata),
      .read_clk_o(rclk), .read_enable_n_o(ren_n), .retransmit_n_o(rt_n));
   dcf_fifo dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(1'b1),
      .master_reset_n_i(mrs_n), .partial_reset_n_i(prs_n), .write_clk_i(wclk),
      .write_enable_n_i(wen_n), .write_data_i(wdata), .offset_load_n_i(load_n),
      .serial_enable_n_i(sen_n), .mode_select_serial_in_i(si), .read_clk_i(rclk),
      .read_enable_n_i(ren_n), .retransmit_n_i(rt_n), .read_data_o(rdata),
      .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n), .almost_empty_n_o(ae_n),
      .almost_full_n_o(af_n), .half_full_n_o(hf_n), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_write_i(reg_wr), .reg_read_i(reg_rd), .reg_rdata_o(reg_rdata));
   // Register port cycles
   task automatic rw(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : rw
   task automatic ck(input logic [1:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      `CHK(v, e)
   endtask : ck
   // Device reset, master or partial, with mode and load pins
   task automatic dres(input logic part, input logic mode, input logic ld);
      @(posedge sys_clk);
      {si, load_n, prs_n, mrs_n} <= {mode, ld, ~part, part};
      repeat (9) @(posedge sys_clk);
      {prs_n, mrs_n} <= 2'h3;
      repeat (8) @(posedge sys_clk);
      {si, load_n} <= {~mode, 1'b1};
   endtask : dres
   // Status word after master reset, before any link clock tick
   function automatic logic [15:0] idle_stat(input logic fw, input logic sl);
      return {8'h00, fw, sl, 6'h29};
   endfunction : idle_stat
   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   initial begin
      #500000 errors++;
      end_sim;
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      dres(1'b0, 1'b0, 1'b0);
      ck(2'h0, 16'h007F);
      ck(2'h1, 16'h007F);
      ck(2'h3, idle_stat(1'b0, 1'b0));
      ofs = 16'($random(seed));
      rw(2'h0, ofs);
      ck(2'h0, ofs);
      $display("parallel offsets done");
      for (int i = 0; i < 4; i++) begin
         q[i] = 18'($random(seed));
         lnk_u.wr(1'b0, q[i]);
      end
      lnk_u.wr(1'b1, ~q[0]);
      repeat (2) lnk_u.rd(1'b1, 1'b1);
      `CHK(ef_n, 1'b1)
      for (int i = 0; i < 4; i++) begin
         lnk_u.rd(1'b0, 1'b1);
         `CHK(rdata, q[i])
      end
      `CHK(ef_n, 1'b0)
      lnk_u.rd(1'b0, 1'b1);
      `CHK(rdata, q[3])
      lnk_u.rd(1'b1, 1'b0);
      `CHK(ef_n, 1'b0)
      repeat (3) lnk_u.rd(1'b1, 1'b1);
      `CHK(ef_n, 1'b1)
      lnk_u.rd(1'b0, 1'b1);
      `CHK(rdata, q[0])
      $display("standard stream and retransmit done");
      dres(1'b1, 1'b1, 1'b1);
      `CHK(ef_n, 1'b0)
      `CHK(ff_n, 1'b1)
      ck(2'h0, ofs);
      $display("partial reset done");
      dres(1'b0, 1'b1, 1'b1);
      ck(2'h0, 16'h03FF);
      rw(2'h1, ofs);
      ck(2'h1, 16'h03FF);
      sv = $random(seed);
      sv[31] = 1'b1; // Full offset stays high, almost-full clear
      for (int i = 31; i >= 0; i--) begin
         @(posedge sys_clk);
         {si, load_n, sen_n} <= {sv[i], 2'h0};
         lnk_u.wr(1'b1, 18'h00000);
      end
      @(posedge sys_clk);
      {load_n, sen_n} <= 2'h3;
      ck(2'h0, sv[15:0]);
      ck(2'h1, sv[31:16]);
      ck(2'h3, idle_stat(1'b1, 1'b1));
      q[0] = 18'($random(seed));
      lnk_u.wr(1'b0, q[0]);
      repeat (3) lnk_u.rd(1'b1, 1'b1);
      `CHK(rdata, q[0])
      `CHK(ef_n, 1'b0)
      lnk_u.rd(1'b0, 1'b1);
      `CHK(ef_n, 1'b1)
      `CHK(rdata, q[0])
      $display("fall-through and serial offsets done");
      end_sim;
   end
endmodule : test_dual_clock_fifo_control
